// ===== design/fcpm_top.sv
/*
 * Five-channel pulse modulator: special function registers, group
 * counter with four duty compares, fifth channel and pin drivers.
 * Assumes the register strobes come from the core on the same clock
 * and that the board resolves each pin from its output and enable.
 */
`timescale 1ns/1ps
`include "fcpm_cfg.svh"

// Contract
// RQ1 - Group counter wraps modulo 256
// RQ2 - Duty above counter drives high
// RQ3 - Duty at or below counter drives low
// RQ4 - Duty 00 constant high, FF constant low
// RQ5 - One polarity bit for whole group
// RQ6 - Set polarity bit inverts its outputs
// RQ7 - Group clock is sysclk/2/(divider+1)
// RQ8 - Group divider lives at B1h, B2h
// RQ9 - Global enable bit starts and stops
// RQ10 - Group drive bits: open-drain or push-pull
// RQ11 - Fifth drive bit: open-drain or push-pull
// RQ12 - Fifth channel has its own polarity
// RQ13 - Fifth clock is sysclk/2/(divider+1)
// RQ14 - Fifth divider at B3h, B4h; zero halves
// RQ15 - Fifth counter compares working registers
// RQ16 - Enabling loads working compare registers
// RQ17 - Fifth goes low at width
// RQ18 - At period clear counter, go high
// RQ19 - Software keeps period nonzero, above width
// RQ20 - Fifth updates take effect at period end
module fcpm_top
    import fcpm_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire fcpm_byte_t sfr_addr_in,
    input  wire fcpm_byte_t sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    output fcpm_byte_t      sfr_rdata_out,
    output logic [3:0]      group_pin_out,
    output logic [3:0]      group_pin_oe_out,
    output logic            fifth_pin_out,
    output logic            fifth_pin_oe_out
);

    // Register file
    fcpm_byte_t modulator_control_q;
    fcpm_byte_t duty_q [4];
    fcpm_byte_t fifth_channel_period_q;
    fcpm_byte_t fifth_channel_pulse_width_q;
    fcpm_div_t  group_divider_q;
    fcpm_div_t  fifth_channel_divider_q;
    fcpm_byte_t rdata_d;

    // Control fields
    logic       group_polarity_select;
    logic       fifth_polarity_select;
    logic       modulator_global_enable;
    logic       fifth_drive_type;
    logic [3:0] group_drive_type;

    // Counters and levels
    fcpm_byte_t group_cnt_q;
    logic       group_tick;
    logic       fifth_tick;
    logic       fifth_running;
    logic       fifth_level;
    fcpm_div_t  fifth_divisor_work;
    logic [3:0] group_raw;
    logic [3:0] group_level;

    // RQ5 group polarity field
    assign group_polarity_select   = modulator_control_q[`FCPM_BIT_GROUP_POL];
    // RQ12 own fifth polarity
    assign fifth_polarity_select   = modulator_control_q[`FCPM_BIT_FIFTH_POL];
    assign modulator_global_enable = modulator_control_q[`FCPM_BIT_ENABLE];
    assign fifth_drive_type        = modulator_control_q[`FCPM_BIT_FIFTH_DRIVE];
    assign group_drive_type =
        modulator_control_q[`FCPM_BIT_GROUP_DRV_HI:`FCPM_BIT_GROUP_DRV_LO];

    // Unpolarised group level; the two end values are pinned explicitly
    function automatic logic fcpm_group_level(input fcpm_byte_t duty,
                                              input fcpm_byte_t cnt);
        if (duty == `FCPM_COUNT_ZERO)
            return 1'b1;
        else if (duty == `FCPM_COUNT_TOP)
            return 1'b0;
        else
            return duty > cnt;
    endfunction

    // Pin drive {out, oe}; open-drain only ever pulls low
    function automatic logic [1:0] fcpm_drive(input logic lvl,
                                              input logic push_pull);
        if (push_pull)
            return {lvl, 1'b1};
        else
            return {1'b0, ~lvl};
    endfunction

    // Register writes; the core owns every byte, nothing is hardware-set
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            modulator_control_q         <= `FCPM_RESET_BYTE;
            duty_q[0]                   <= `FCPM_RESET_BYTE;
            duty_q[1]                   <= `FCPM_RESET_BYTE;
            duty_q[2]                   <= `FCPM_RESET_BYTE;
            duty_q[3]                   <= `FCPM_RESET_BYTE;
            fifth_channel_period_q      <= `FCPM_RESET_BYTE;
            fifth_channel_pulse_width_q <= `FCPM_RESET_BYTE;
            group_divider_q             <= `FCPM_RESET_DIV;
            fifth_channel_divider_q     <= `FCPM_RESET_DIV;
        end
        else if (sfr_wr_in)
        begin
            case (sfr_addr_in)
                `FCPM_ADDR_CONTROL:
                    modulator_control_q <= sfr_wdata_in;
                `FCPM_ADDR_DUTY0:
                    duty_q[0] <= sfr_wdata_in;
                `FCPM_ADDR_DUTY1:
                    duty_q[1] <= sfr_wdata_in;
                `FCPM_ADDR_DUTY2:
                    duty_q[2] <= sfr_wdata_in;
                `FCPM_ADDR_DUTY3:
                    duty_q[3] <= sfr_wdata_in;
                // RQ20 writes accepted while running
                `FCPM_ADDR_FIFTH_PERIOD:
                    fifth_channel_period_q <= sfr_wdata_in;
                `FCPM_ADDR_FIFTH_WIDTH:
                    fifth_channel_pulse_width_q <= sfr_wdata_in;
                // RQ8 group divider bytes
                `FCPM_ADDR_GROUP_DIV_LO:
                    group_divider_q[7:0] <= sfr_wdata_in;
                `FCPM_ADDR_GROUP_DIV_HI:
                    group_divider_q[15:8] <= sfr_wdata_in;
                // RQ14 fifth divider bytes
                `FCPM_ADDR_FIFTH_DIV_LO:
                    fifth_channel_divider_q[7:0] <= sfr_wdata_in;
                `FCPM_ADDR_FIFTH_DIV_HI:
                    fifth_channel_divider_q[15:8] <= sfr_wdata_in;
                default:
                    ; // Unmapped writes are dropped
            endcase
        end
    end

    // Read decode; unmapped addresses answer zero
    always_comb
    begin
        rdata_d = `FCPM_RESET_BYTE;
        case (sfr_addr_in)
            `FCPM_ADDR_CONTROL:      rdata_d = modulator_control_q;
            `FCPM_ADDR_DUTY0:        rdata_d = duty_q[0];
            `FCPM_ADDR_DUTY1:        rdata_d = duty_q[1];
            `FCPM_ADDR_DUTY2:        rdata_d = duty_q[2];
            `FCPM_ADDR_DUTY3:        rdata_d = duty_q[3];
            `FCPM_ADDR_FIFTH_PERIOD: rdata_d = fifth_channel_period_q;
            `FCPM_ADDR_FIFTH_WIDTH:  rdata_d = fifth_channel_pulse_width_q;
            `FCPM_ADDR_GROUP_DIV_LO: rdata_d = group_divider_q[7:0];
            `FCPM_ADDR_GROUP_DIV_HI: rdata_d = group_divider_q[15:8];
            `FCPM_ADDR_FIFTH_DIV_LO: rdata_d = fifth_channel_divider_q[7:0];
            `FCPM_ADDR_FIFTH_DIV_HI: rdata_d = fifth_channel_divider_q[15:8];
            default:                 rdata_d = `FCPM_RESET_BYTE;
        endcase
    end

    // Read data registered; it holds between reads
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sfr_rdata_out <= `FCPM_RESET_BYTE;
        else if (sfr_rd_in)
            sfr_rdata_out <= rdata_d;
    end

    // RQ7 group prescaler
    fcpm_divider u_group_div (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (modulator_global_enable),
        .divisor_in (group_divider_q),
        .tick_out   (group_tick)
    );

    // RQ13 fifth prescaler, fed the working divisor so it changes per period
    fcpm_divider u_fifth_div (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (fifth_running),
        .divisor_in (fifth_divisor_work),
        .tick_out   (fifth_tick)
    );

    // Fifth channel counter and compares
    fcpm_fifth u_fifth (
        .ref_clk_in       (ref_clk_in),
        .nrst_in          (nrst_in),
        .enable_in        (modulator_global_enable),
        .tick_in          (fifth_tick),
        .period_in        (fifth_channel_period_q),
        .width_in         (fifth_channel_pulse_width_q),
        .divisor_in       (fifth_channel_divider_q),
        .running_out      (fifth_running),
        .level_out        (fifth_level),
        .divisor_work_out (fifth_divisor_work)
    );

    // Group counter; restarts from zero each time the block is enabled
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            group_cnt_q <= `FCPM_COUNT_ZERO;
        else if (!modulator_global_enable)
            group_cnt_q <= `FCPM_COUNT_ZERO;
        // RQ1 natural 8-bit wrap
        else if (group_tick)
            group_cnt_q <= group_cnt_q + `FCPM_COUNT_ONE;
    end

    // Group compares and polarity
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            // RQ2 RQ3 RQ4 duty compare
            group_raw[i]   = fcpm_group_level(duty_q[i], group_cnt_q);
            // RQ6 polarity inversion
            group_level[i] = group_raw[i] ^ group_polarity_select;
        end
    end

    // Pin drivers; disabled pins are released rather than driven
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            group_pin_out    <= 4'h0;
            group_pin_oe_out <= 4'h0;
            fifth_pin_out    <= 1'b0;
            fifth_pin_oe_out <= 1'b0;
        end
        // RQ9 global enable gate
        else if (!modulator_global_enable)
        begin
            group_pin_out    <= 4'h0;
            group_pin_oe_out <= 4'h0;
            fifth_pin_out    <= 1'b0;
            fifth_pin_oe_out <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                // RQ10 group drive type
                {group_pin_out[i], group_pin_oe_out[i]} <=
                    fcpm_drive(group_level[i], group_drive_type[i]);
            end
            // RQ11 fifth drive type
            {fifth_pin_out, fifth_pin_oe_out} <=
                fcpm_drive(fifth_level ^ fifth_polarity_select,
                           fifth_drive_type);
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    AST_GROUP_WRAP: assert property ( // RQ1
        modulator_global_enable && group_tick
            && group_cnt_q == `FCPM_COUNT_TOP |=>
            group_cnt_q == `FCPM_COUNT_ZERO)
        else $error("group counter did not wrap to zero");

    AST_GROUP_STEP: assert property ( // RQ1
        modulator_global_enable && group_tick
            && group_cnt_q != `FCPM_COUNT_TOP |=>
            group_cnt_q == $past(group_cnt_q) + 8'h01)
        else $error("group counter did not step by one");

    AST_GROUP_HIGH: assert property ( // RQ2
        modulator_global_enable && !group_polarity_select
            && group_drive_type[0] && duty_q[0] > group_cnt_q
            && duty_q[0] != `FCPM_COUNT_TOP |=> group_pin_out[0])
        else $error("channel zero not high with duty above count");

    AST_GROUP_LOW: assert property ( // RQ3
        modulator_global_enable && !group_polarity_select
            && group_drive_type[0] && duty_q[0] <= group_cnt_q
            && duty_q[0] != `FCPM_COUNT_ZERO |=> !group_pin_out[0])
        else $error("channel zero not low with duty at or below count");

    AST_GROUP_ENDS: assert property ( // RQ4
        modulator_global_enable && !group_polarity_select
            && group_drive_type[1] |=>
            ($past(duty_q[1]) == 8'h00 -> group_pin_out[1])
            && ($past(duty_q[1]) == 8'hFF -> !group_pin_out[1]))
        else $error("end duty values not held constant");

    AST_POL_INVERT: assert property ( // RQ6
        modulator_global_enable && group_polarity_select
            && group_drive_type[2] |=>
            group_pin_out[2] == !$past(group_raw[2]))
        else $error("group polarity did not invert channel two");

    // RQ7 divide by two
    // Enable must hold over the whole pair, or a late disable trips this
    AST_TICK_FAST: assert property ( // RQ7
        modulator_global_enable && group_divider_q == 16'h0000
            && $past(modulator_global_enable)
            && $past(modulator_global_enable, 2) && $past(group_tick, 2) |->
            group_tick && !$past(group_tick))
        else $error("group tick not every second cycle at divisor zero");

    AST_DISABLED: assert property ( // RQ9
        !modulator_global_enable |=>
            group_pin_oe_out == 4'h0 && !fifth_pin_oe_out
            && group_cnt_q == `FCPM_COUNT_ZERO)
        else $error("outputs still driven while disabled");

    AST_OPEN_DRAIN: assert property ( // RQ10
        modulator_global_enable && !group_drive_type[3] |=>
            !group_pin_out[3] && group_pin_oe_out[3] == !$past(group_level[3]))
        else $error("open-drain channel three drove high");

    AST_FIFTH_PIN: assert property ( // RQ11
        modulator_global_enable && fifth_drive_type |=>
            fifth_pin_oe_out
            && fifth_pin_out == $past(fifth_level ^ fifth_polarity_select))
        else $error("fifth push-pull pin level wrong");

endmodule

// ===== shared/fcpm_cfg.svh
/*
 * Offsets, field positions, reset values and divider constants of the
 * five-channel pulse modulator.
 * Assumes it is included by bare name wherever these macros are needed.
 */
`ifndef FCPM_CFG_SVH
`define FCPM_CFG_SVH

// Special function register addresses
`define FCPM_ADDR_CONTROL       8'hA1
`define FCPM_ADDR_DUTY0         8'hA2
`define FCPM_ADDR_DUTY1         8'hA3
`define FCPM_ADDR_DUTY2         8'hA4
`define FCPM_ADDR_DUTY3         8'hA5
`define FCPM_ADDR_FIFTH_PERIOD  8'hAA
`define FCPM_ADDR_FIFTH_WIDTH   8'hAB
`define FCPM_ADDR_GROUP_DIV_LO  8'hB1
`define FCPM_ADDR_GROUP_DIV_HI  8'hB2
`define FCPM_ADDR_FIFTH_DIV_LO  8'hB3
`define FCPM_ADDR_FIFTH_DIV_HI  8'hB4

// Control register field positions
`define FCPM_BIT_GROUP_POL      7
`define FCPM_BIT_FIFTH_POL      6
`define FCPM_BIT_ENABLE         5
`define FCPM_BIT_FIFTH_DRIVE    4
`define FCPM_BIT_GROUP_DRV_HI   3
`define FCPM_BIT_GROUP_DRV_LO   0

// Reset value of every register
`define FCPM_RESET_BYTE         8'h00
`define FCPM_RESET_DIV          16'h0000

// Counter limits
`define FCPM_COUNT_ZERO         8'h00
`define FCPM_COUNT_TOP          8'hFF
`define FCPM_COUNT_ONE          8'h01
`define FCPM_DIV_ONE            16'h0001

`endif

// ===== shared/fcpm_pkg.sv
/*
 * Types shared by the five-channel pulse modulator modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fcpm_pkg;

    typedef logic [7:0]  fcpm_byte_t;
    typedef logic [15:0] fcpm_div_t;

    // Run state of the fifth channel
    typedef enum logic {
        FCPM_IDLE,
        FCPM_RUN
    } fcpm_run_t;

endpackage

// ===== design/fcpm_divider.sv
/*
 * Prescaler: fixed divide by two, then divide by divisor plus one.
 * Assumes run_in and divisor_in come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "fcpm_cfg.svh"

module fcpm_divider
    import fcpm_pkg::*;
(
    input  wire logic      ref_clk_in,
    input  wire logic      nrst_in,
    input  wire logic      run_in,
    input  wire fcpm_div_t divisor_in,
    output logic           tick_out
);

    logic      half_q;
    fcpm_div_t cnt_q;

    // One tick every 2 * (divisor + 1) cycles; >= copes with a shrunk value
    assign tick_out = run_in && half_q && (cnt_q >= divisor_in);

    // Half-rate phase and divisor count, both cleared while stopped
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            half_q <= 1'b0;
            cnt_q  <= `FCPM_RESET_DIV;
        end
        else if (!run_in)
        begin
            half_q <= 1'b0;
            cnt_q  <= `FCPM_RESET_DIV;
        end
        else
        begin
            half_q <= ~half_q;
            if (half_q)
                cnt_q <= (cnt_q >= divisor_in) ? `FCPM_RESET_DIV
                                               : cnt_q + `FCPM_DIV_ONE;
        end
    end

endmodule

// ===== design/fcpm_fifth.sv
/*
 * Fifth channel: working compare registers, period counter and level.
 * Assumes tick_in comes from the divider fed by divisor_work_out.
 */
`timescale 1ns/1ps
`include "fcpm_cfg.svh"

module fcpm_fifth
    import fcpm_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       enable_in,
    input  wire logic       tick_in,
    input  wire fcpm_byte_t period_in,
    input  wire fcpm_byte_t width_in,
    input  wire fcpm_div_t  divisor_in,
    output logic            running_out,
    output logic            level_out,
    output fcpm_div_t       divisor_work_out
);

    fcpm_run_t  state_q;
    fcpm_byte_t cnt_q;
    fcpm_byte_t period_w_q;
    fcpm_byte_t width_w_q;
    logic       period_end;

    // RQ19 period assumed nonzero
    assign period_end  = tick_in && (cnt_q == period_w_q);
    assign running_out = (state_q == FCPM_RUN);
    // RQ17 low from width on
    assign level_out   = running_out && (cnt_q < width_w_q);

    // Load on enable, reload at period end, count on every tick
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q          <= FCPM_IDLE;
            cnt_q            <= `FCPM_COUNT_ZERO;
            period_w_q       <= `FCPM_RESET_BYTE;
            width_w_q        <= `FCPM_RESET_BYTE;
            divisor_work_out <= `FCPM_RESET_DIV;
        end
        else
        begin
            case (state_q)
                FCPM_IDLE:
                begin
                    cnt_q <= `FCPM_COUNT_ZERO;
                    if (enable_in)
                    begin
                        // RQ16 load before compare
                        period_w_q       <= period_in;
                        width_w_q        <= width_in;
                        divisor_work_out <= divisor_in;
                        state_q          <= FCPM_RUN;
                    end
                end
                FCPM_RUN:
                begin
                    if (!enable_in)
                        state_q <= FCPM_IDLE;
                    else if (period_end)
                    begin
                        // RQ18 clear at period
                        cnt_q            <= `FCPM_COUNT_ZERO;
                        // RQ20 reload at end
                        period_w_q       <= period_in;
                        width_w_q        <= width_in;
                        divisor_work_out <= divisor_in;
                    end
                    // RQ15 period counter, restarted at period end
                    else if (tick_in)
                        cnt_q <= cnt_q + `FCPM_COUNT_ONE;
                end
                default:
                    state_q <= FCPM_IDLE;
            endcase
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    AST_FIFTH_LOAD: assert property ( // RQ16
        state_q == FCPM_IDLE && enable_in |=>
            running_out && period_w_q == $past(period_in)
            && width_w_q == $past(width_in))
        else $error("fifth channel did not load compare values");

    AST_FIFTH_WRAP: assert property ( // RQ18
        running_out && enable_in && period_end |=>
            cnt_q == `FCPM_COUNT_ZERO && level_out == (width_w_q != 8'h00))
        else $error("fifth channel counter did not restart at period");

    AST_FIFTH_HOLD: assert property ( // RQ20
        running_out && enable_in && !period_end |=> $stable(width_w_q)
            && $stable(period_w_q) && $stable(divisor_work_out))
        else $error("fifth compare values changed inside a period");

endmodule

// ===== sim/fcpm_load.sv
/*
 * Model of the board around the five modulator pins: each pin has a
 * pull-up, so a released pin reads high.
 * Assumes the design drives out and oe from the same clock.
 */
`timescale 1ns/1ps

module fcpm_load
    import fcpm_pkg::*;
(
    input  wire logic [3:0] group_pin_in,
    input  wire logic [3:0] group_oe_in,
    input  wire logic       fifth_pin_in,
    input  wire logic       fifth_oe_in,
    output logic [3:0]      group_wire_out,
    output logic            fifth_wire_out
);
    // Pull-up wins whenever a pin is released, so open-drain high is real
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            group_wire_out[i] = group_oe_in[i] ? group_pin_in[i] : 1'b1;
        fifth_wire_out = fifth_oe_in ? fifth_pin_in : 1'b1;
    end
endmodule

// ===== sim/testbench.sv
/*
 * Self-checking bench for the five-channel pulse modulator.
 * Assumes fcpm_top and fcpm_load; levels are judged at the pull-up wire.
 */
`timescale 1ns/1ps
`include "fcpm_cfg.svh"

module testbench
    import fcpm_pkg::*;
;
    typedef struct {
        fcpm_byte_t ctrl, duty, div, per, wid;
        int         eg, ef;
    } fcpm_row_t;
    logic        ref_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    fcpm_byte_t  sfr_addr_in = 8'h00;
    fcpm_byte_t  sfr_wdata_in = 8'h00;
    logic        sfr_wr_in = 1'b0;
    logic        sfr_rd_in = 1'b0;
    fcpm_byte_t  sfr_rdata_out, rd_val;
    logic [3:0]  group_pin_out, group_pin_oe_out, grp_wire;
    logic        fifth_pin_out, fifth_pin_oe_out, fifth_wire;
    int          err_count = 0;
    int          samples_checked = 0;
    logic [15:0] g_cnt [4];
    logic [15:0] f_cnt;
    int          win;
    // Group window is 512*(div+1); fifth highs follow 2*width per 2*(per+1)
    fcpm_row_t rows [7] = '{
        '{8'h3F, 8'h00, 8'h00, 8'h3F, 8'h10, 512, 128},
        '{8'h22, 8'hFF, 8'h00, 8'hFF, 8'hFE, 0, 508},
        '{8'h35, 8'h01, 8'h00, 8'h3F, 8'h00, 2, 0},
        '{8'h2A, 8'h80, 8'h00, 8'hFF, 8'h01, 256, 2},
        '{8'hEF, 8'h40, 8'h00, 8'h3F, 8'h10, 384, 384},
        '{8'hA0, 8'h00, 8'h00, 8'h7F, 8'h40, 0, 256},
        '{8'h6F, 8'h40, 8'h01, 8'h3F, 8'h10, 256, 768}};

    fcpm_top fcpm_top_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out), .group_pin_out(group_pin_out),
        .group_pin_oe_out(group_pin_oe_out), .fifth_pin_out(fifth_pin_out),
        .fifth_pin_oe_out(fifth_pin_oe_out));
    fcpm_load fcpm_load_i (.group_pin_in(group_pin_out),
        .group_oe_in(group_pin_oe_out), .fifth_pin_in(fifth_pin_out),
        .fifth_oe_in(fifth_pin_oe_out), .group_wire_out(grp_wire),
        .fifth_wire_out(fifth_wire));

    // 100 MHz system clock
    always #5 ref_clk_in = ~ref_clk_in;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // One-cycle strobe, held until the edge that takes it
    task automatic wr(input fcpm_byte_t a, input fcpm_byte_t d);
    begin
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b0;
    end
    endtask

    task automatic rd(input fcpm_byte_t a);
    begin
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        rd_val = sfr_rdata_out;
    end
    endtask

    // Count high cycles at the wire; any whole number of periods works
    task automatic measure(input int n);
    begin
        f_cnt = 16'h0000;
        for (int i = 0; i < 4; i++)
            g_cnt[i] = 16'h0000;
        repeat (n)
        begin
            @(negedge ref_clk_in);
            for (int i = 0; i < 4; i++)
                g_cnt[i] += 16'(grp_wire[i]);
            f_cnt += 16'(fifth_wire);
        end
    end
    endtask

    task automatic wrap_up;
    begin
        $display("Checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    // Watchdog: whole run is about 15k cycles, so 30k means a hang
    initial
    begin
        #300000;
        err_count++;
        wrap_up();
    end

    initial
    begin
        fcpm_byte_t a;
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        // Reset values, then readback of every register and a hole
        for (int i = 0; i < 11; i++)
        begin
            a = (i < 5) ? 8'(8'hA1 + i) : (i < 7) ? 8'(8'hA5 + i) : 8'(8'hAA + i);
            rd(a);
            chk(16'(rd_val), 16'h0000);
            // Pattern keeps the enable bit clear while period is still zero
            wr(a, 8'(a ^ 8'h7A));
            rd(a);
            chk(16'(rd_val), 16'(a ^ 8'h7A));
        end
        wr(8'hA6, 8'hFF);
        rd(8'hA6);
        chk(16'(rd_val), 16'h0000);
        $display("Test registers done");
        // rows keep period nonzero and above width
        foreach (rows[r])
        begin
            wr(`FCPM_ADDR_CONTROL, 8'h00);
            for (int i = 0; i < 4; i++)
                wr(8'(`FCPM_ADDR_DUTY0 + i), rows[r].duty);
            wr(`FCPM_ADDR_GROUP_DIV_LO, rows[r].div);
            wr(`FCPM_ADDR_GROUP_DIV_HI, 8'h00);
            wr(`FCPM_ADDR_FIFTH_DIV_LO, 8'h00);
            wr(`FCPM_ADDR_FIFTH_DIV_HI, 8'h00);
            wr(`FCPM_ADDR_FIFTH_PERIOD, rows[r].per);
            wr(`FCPM_ADDR_FIFTH_WIDTH, rows[r].wid);
            wr(`FCPM_ADDR_CONTROL, rows[r].ctrl);
            win = 512 * (int'(rows[r].div) + 1);
            repeat (2 * win) @(posedge ref_clk_in);
            measure(win);
            for (int i = 0; i < 4; i++)
                chk(g_cnt[i], 16'(rows[r].eg));
            chk(f_cnt, 16'(rows[r].ef));
            chk(16'(group_pin_oe_out & rows[r].ctrl[3:0]), 16'(rows[r].ctrl[3:0]));
            chk(16'(group_pin_out & ~rows[r].ctrl[3:0]), 16'h0000);
            chk(16'({fifth_pin_oe_out | ~rows[r].ctrl[4]}), 16'h0001);
            $display("Test row %0d done", r);
        end
        // Fifth width and divider changed while running take hold later
        wr(`FCPM_ADDR_FIFTH_WIDTH, 8'h20);
        wr(`FCPM_ADDR_FIFTH_DIV_LO, 8'h01);
        repeat (1024) @(posedge ref_clk_in);
        measure(512);
        chk(f_cnt, 16'd256);
        $display("Test live update done");
        // Disable releases every pin
        wr(`FCPM_ADDR_CONTROL, 8'h0F);
        repeat (3) @(posedge ref_clk_in);
        chk(16'({group_pin_oe_out, fifth_pin_oe_out}), 16'h0000);
        // Reset in mid-run clears pins and control
        wr(`FCPM_ADDR_CONTROL, 8'h3F);
        repeat (600) @(posedge ref_clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        chk(16'({group_pin_out, group_pin_oe_out, fifth_pin_out}), 16'h0000);
        nrst_in <= 1'b1;
        rd(`FCPM_ADDR_CONTROL);
        chk(16'(rd_val), 16'h0000);
        $display("Test disable and reset done");
        wrap_up();
    end
endmodule
